//--- rtl/fsl_failsafe_regs.sv
// fail-safe switch states, current-limit configuration and spi watchdog
// assumes the serial front end decodes frames into one-cycle register strobes
`timescale 1ns/100ps
// Function
// R1: on serial or watchdog error apply fail-safe states
// R2: bits 3..0 map channels 4..1, 1 means on
// R3: fail-safe register resets to all zeros
// R4: pair a bits 7..4 select inrush time
// R5: pair a bits 3..0 select regulated limit
// R6: pair b bits 7..4 select inrush time
// R7: pair b bits 3..0 select regulated limit
// R8: both limit registers reset to 0Ah
// R9: split select gives channels 3/4 own register
// R10: mode bit picks inrush or limit-before-off duration
// R11: enabled watchdog errors if host idle past timeout
// R12: reserved fail-safe bits read zero, ignore writes
module fsl_failsafe_regs #(
  parameter int unsigned WD_CYC_0 = fsl_pkg::FSL_WD_TO0_CYC,
  parameter int unsigned WD_CYC_1 = fsl_pkg::FSL_WD_TO1_CYC,
  parameter int unsigned WD_CYC_2 = fsl_pkg::FSL_WD_TO2_CYC,
  parameter int unsigned WD_CYC_3 = fsl_pkg::FSL_WD_TO3_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  input wire logic [3:0] sw_state,
  input wire logic spi_error,
  input wire logic split_limit_select,
  input wire logic limit_duration_mode,
  input wire logic watchdog_enable_bit,
  input wire logic [1:0] watchdog_timeout_sel,
  output logic [3:0] chan_on_q,
  output fsl_pkg::fsl_limit_t limit_ch12_q,
  output fsl_pkg::fsl_limit_t limit_ch34_q,
  output logic duration_mode_q,
  output logic watchdog_error_q,
  output logic failsafe_active_q
);
  import fsl_pkg::*;

  logic [7:0] failsafe_switch_state_q;
  logic [7:0] cfg_a_q;
  logic [7:0] cfg_b_q;
  logic [FSL_WD_CNT_W-1:0] wd_cnt_q;
  logic [FSL_WD_CNT_W-1:0] wd_limit;
  logic host_access;
  logic fail_now;
  logic [7:0] cfg_b_eff;

  assign host_access = reg_wr_en | reg_rd_en;
  assign fail_now = spi_error | watchdog_error_q;
  assign cfg_b_eff = split_limit_select ? cfg_b_q : cfg_a_q; // R9

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      failsafe_switch_state_q <= FSL_RST_FAILSAFE; // R3
      cfg_a_q <= FSL_RST_CFG; // R8
      cfg_b_q <= FSL_RST_CFG; // R8
    end else if (reg_wr_en) begin
      case (reg_addr)
        FSL_ADDR_FAILSAFE: failsafe_switch_state_q <= reg_wdata & FSL_FAILSAFE_MASK; // R12
        FSL_ADDR_CFG_A: cfg_a_q <= reg_wdata;
        FSL_ADDR_CFG_B: cfg_b_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // only the addressed register may move
  AST_WR_A: assert property (@(posedge core_clk) disable iff (sys_rst) // R4
    reg_wr_en && reg_addr == FSL_ADDR_CFG_A |=> cfg_a_q == $past(reg_wdata))
    else $error("pair a register missed a write");
  AST_WR_B: assert property (@(posedge core_clk) disable iff (sys_rst) // R6
    reg_wr_en && reg_addr == FSL_ADDR_CFG_B |=> cfg_b_q == $past(reg_wdata))
    else $error("pair b register missed a write");
  AST_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst) // R8
    !reg_wr_en |=>
      $stable(cfg_a_q) && $stable(cfg_b_q) && $stable(failsafe_switch_state_q))
    else $error("register changed without a write");

  // unmapped reads return zero so the frame stays defined
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd_en) begin
      case (reg_addr)
        FSL_ADDR_FAILSAFE: reg_rdata_q <= failsafe_switch_state_q;
        FSL_ADDR_CFG_A: reg_rdata_q <= cfg_a_q;
        FSL_ADDR_CFG_B: reg_rdata_q <= cfg_b_q;
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  AST_RD_FS: assert property (@(posedge core_clk) disable iff (sys_rst) // R12
    reg_rd_en && reg_addr == FSL_ADDR_FAILSAFE |=>
      reg_rdata_q == $past(failsafe_switch_state_q) && reg_rdata_q[7:4] == 4'h0)
    else $error("fail-safe read back wrong");
  AST_RD_A: assert property (@(posedge core_clk) disable iff (sys_rst) // R5
    reg_rd_en && reg_addr == FSL_ADDR_CFG_A |=> reg_rdata_q == $past(cfg_a_q))
    else $error("pair a read back wrong");
  AST_RD_B: assert property (@(posedge core_clk) disable iff (sys_rst) // R7
    reg_rd_en && reg_addr == FSL_ADDR_CFG_B |=> reg_rdata_q == $past(cfg_b_q))
    else $error("pair b read back wrong");

  always_comb begin
    case (watchdog_timeout_sel)
      2'h0: wd_limit = FSL_WD_CNT_W'(WD_CYC_0 - 1);
      2'h1: wd_limit = FSL_WD_CNT_W'(WD_CYC_1 - 1);
      2'h2: wd_limit = FSL_WD_CNT_W'(WD_CYC_2 - 1);
      default: wd_limit = FSL_WD_CNT_W'(WD_CYC_3 - 1);
    endcase
  end

  // any host access restarts the window and clears a past error
  always_ff @(posedge core_clk) begin
    if (sys_rst || !watchdog_enable_bit || host_access) begin
      wd_cnt_q <= '0;
    end else if (wd_cnt_q < wd_limit) begin
      wd_cnt_q <= wd_cnt_q + 1'b1; // R11
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || !watchdog_enable_bit) begin
      watchdog_error_q <= 1'b0;
    end else if (!host_access && wd_cnt_q >= wd_limit) begin
      watchdog_error_q <= 1'b1; // R11
    end else if (host_access) begin
      watchdog_error_q <= 1'b0;
    end
  end

  // error must clear on any access or disable
  AST_WD_CLEAR: assert property (@(posedge core_clk) disable iff (sys_rst) // R11
    host_access |=> !watchdog_error_q)
    else $error("watchdog error survived a host access");
  AST_WD_DIS: assert property (@(posedge core_clk) disable iff (sys_rst) // R11
    !watchdog_enable_bit |=> !watchdog_error_q && wd_cnt_q == '0)
    else $error("watchdog active while disabled");
  AST_WD_LIMIT: assert property (@(posedge core_clk) disable iff (sys_rst) // R11
    $rose(watchdog_error_q) |-> $past(wd_cnt_q) >= $past(wd_limit))
    else $error("watchdog error before timeout");

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      chan_on_q <= 4'h0;
      failsafe_active_q <= 1'b0;
    end else begin
      chan_on_q <= fail_now ? failsafe_switch_state_q[3:0] : sw_state; // R1 R2
      failsafe_active_q <= fail_now;
    end
  end

  AST_FS_WD: assert property (@(posedge core_clk) disable iff (sys_rst) // R1
    watchdog_error_q |=>
      chan_on_q == $past(failsafe_switch_state_q[3:0]) && failsafe_active_q)
    else $error("fail-safe state not applied on watchdog error");
  AST_FS_OFF: assert property (@(posedge core_clk) disable iff (sys_rst) // R3
    fail_now && failsafe_switch_state_q == FSL_RST_FAILSAFE |=> chan_on_q == 4'h0)
    else $error("unprogrammed fail-safe left a channel on");

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      limit_ch12_q <= '{inrush_ms: fsl_dur_ms(FSL_RST_CFG[7:4]), limit_ma: fsl_lim_ma(FSL_RST_CFG[3:0])};
      limit_ch34_q <= '{inrush_ms: fsl_dur_ms(FSL_RST_CFG[7:4]), limit_ma: fsl_lim_ma(FSL_RST_CFG[3:0])};
      duration_mode_q <= 1'b0;
    end else begin
      limit_ch12_q.inrush_ms <= fsl_dur_ms(cfg_a_q[FSL_TIME_HI:FSL_TIME_LO]); // R4
      limit_ch12_q.limit_ma <= fsl_lim_ma(cfg_a_q[FSL_LEVEL_HI:FSL_LEVEL_LO]); // R5
      limit_ch34_q.inrush_ms <= fsl_dur_ms(cfg_b_eff[FSL_TIME_HI:FSL_TIME_LO]); // R6
      limit_ch34_q.limit_ma <= fsl_lim_ma(cfg_b_eff[FSL_LEVEL_HI:FSL_LEVEL_LO]); // R7
      duration_mode_q <= limit_duration_mode; // R10
    end
  end

  // limits must track the live register copy
  AST_TIME_A: assert property (@(posedge core_clk) disable iff (sys_rst) // R4
    1'h1 |=> limit_ch12_q.inrush_ms == fsl_dur_ms($past(cfg_a_q[7:4])))
    else $error("pair a inrush time not decoded");
  AST_LVL_A: assert property (@(posedge core_clk) disable iff (sys_rst) // R5
    1'h1 |=> limit_ch12_q.limit_ma == fsl_lim_ma($past(cfg_a_q[3:0])))
    else $error("pair a limit level not decoded");
  AST_TIME_B: assert property (@(posedge core_clk) disable iff (sys_rst) // R6
    split_limit_select |=> limit_ch34_q.inrush_ms == fsl_dur_ms($past(cfg_b_q[7:4])))
    else $error("pair b inrush time not used while split");
  AST_MODE_FOLLOW: assert property (@(posedge core_clk) disable iff (sys_rst) // R10
    1'h1 |=> duration_mode_q == $past(limit_duration_mode))
    else $error("duration mode copy stale");

  AST_FS_APPLY: assert property (@(posedge core_clk) disable iff (sys_rst) // R1
    spi_error |=> chan_on_q == $past(failsafe_switch_state_q[3:0]) && failsafe_active_q)
    else $error("fail-safe state not applied on serial error");
  AST_NORMAL: assert property (@(posedge core_clk) disable iff (sys_rst) // R2
    !spi_error && !watchdog_error_q |=> chan_on_q == $past(sw_state) && !failsafe_active_q)
    else $error("normal switch state not applied");
  AST_FS_RESET: assert property (@(posedge core_clk) // R3
    sys_rst |=> failsafe_switch_state_q == 8'h00 && chan_on_q == 4'h0)
    else $error("fail-safe register not zero after reset");
  AST_CFG_RESET: assert property (@(posedge core_clk) // R8
    sys_rst |=> cfg_a_q == 8'h0a && cfg_b_q == 8'h0a && limit_ch12_q.limit_ma == 12'h4e2)
    else $error("limit registers not 0Ah after reset");
  AST_RSVD: assert property (@(posedge core_clk) disable iff (sys_rst) // R12
    reg_wr_en && reg_addr == FSL_ADDR_FAILSAFE |=> failsafe_switch_state_q == {4'h0, $past(reg_wdata[3:0])})
    else $error("reserved fail-safe bits not zero");
  AST_PAIR_A: assert property (@(posedge core_clk) disable iff (sys_rst) // R4
    reg_wr_en && reg_addr == FSL_ADDR_CFG_A ##1 !reg_wr_en |=>
      limit_ch12_q.inrush_ms == fsl_dur_ms($past(reg_wdata[7:4], 2)) &&
      limit_ch12_q.limit_ma == fsl_lim_ma($past(reg_wdata[3:0], 2)))
    else $error("pair a limit not taken from written value");
  AST_SHARED: assert property (@(posedge core_clk) disable iff (sys_rst) // R9
    !split_limit_select |=> limit_ch34_q == limit_ch12_q)
    else $error("channels 3/4 differ from pair a while shared");
  AST_SPLIT: assert property (@(posedge core_clk) disable iff (sys_rst) // R7
    split_limit_select |=> limit_ch34_q.limit_ma == fsl_lim_ma($past(cfg_b_q[3:0])))
    else $error("pair b limit not used while split");
  AST_MODE: assert property (@(posedge core_clk) disable iff (sys_rst) // R10
    $changed(limit_duration_mode) |=> duration_mode_q == $past(limit_duration_mode))
    else $error("duration mode not followed");
  AST_WD_OFF: assert property (@(posedge core_clk) disable iff (sys_rst) // R11
    $rose(watchdog_error_q) |-> $past(watchdog_enable_bit) && !$past(host_access))
    else $error("watchdog error without enable or despite access");
endmodule // fsl_failsafe_regs

//--- rtl/fsl_pkg.sv
// fail-safe and current-limit register bank: shared constants, types, decoders
// assumes a 100 MHz register clock
package fsl_pkg;
  localparam logic [7:0] FSL_ADDR_FAILSAFE = 8'h20;
  localparam logic [7:0] FSL_ADDR_CFG_A = 8'h21;
  localparam logic [7:0] FSL_ADDR_CFG_B = 8'h22;
  localparam logic [7:0] FSL_RST_FAILSAFE = 8'h00;
  localparam logic [7:0] FSL_RST_CFG = 8'h0a;
  localparam logic [7:0] FSL_FAILSAFE_MASK = 8'h0f;
  localparam int FSL_TIME_HI = 7;
  localparam int FSL_TIME_LO = 4;
  localparam int FSL_LEVEL_HI = 3;
  localparam int FSL_LEVEL_LO = 0;
  localparam int FSL_CLK_MHZ = 100;
  localparam int FSL_WD_TO0_US = 400;
  localparam int FSL_WD_TO1_US = 400000;
  localparam int FSL_WD_TO2_US = 800000;
  localparam int FSL_WD_TO3_US = 1200000;
  localparam int FSL_WD_TO0_CYC = FSL_WD_TO0_US * FSL_CLK_MHZ;
  localparam int FSL_WD_TO1_CYC = FSL_WD_TO1_US * FSL_CLK_MHZ;
  localparam int FSL_WD_TO2_CYC = FSL_WD_TO2_US * FSL_CLK_MHZ;
  localparam int FSL_WD_TO3_CYC = FSL_WD_TO3_US * FSL_CLK_MHZ;
  localparam int FSL_WD_CNT_W = 27;

  typedef struct packed {
    logic [6:0] inrush_ms;
    logic [11:0] limit_ma;
  } fsl_limit_t;

  function automatic logic [6:0] fsl_dur_ms(input logic [3:0] code);
    case (code)
      4'h0: fsl_dur_ms = 7'h00;
      4'h1: fsl_dur_ms = 7'h02;
      4'h2: fsl_dur_ms = 7'h04;
      4'h3: fsl_dur_ms = 7'h06;
      4'h4: fsl_dur_ms = 7'h08;
      4'h5: fsl_dur_ms = 7'h0a;
      4'h6: fsl_dur_ms = 7'h0c;
      4'h7: fsl_dur_ms = 7'h10;
      4'h8: fsl_dur_ms = 7'h14;
      4'h9: fsl_dur_ms = 7'h18;
      4'ha: fsl_dur_ms = 7'h1c;
      4'hb: fsl_dur_ms = 7'h20;
      4'hc: fsl_dur_ms = 7'h28;
      4'hd: fsl_dur_ms = 7'h30;
      4'he: fsl_dur_ms = 7'h38;
      default: fsl_dur_ms = 7'h40;
    endcase
  endfunction

  // regulated limit in milliamps
  function automatic logic [11:0] fsl_lim_ma(input logic [3:0] code);
    case (code)
      4'h0: fsl_lim_ma = 12'h0fa;
      4'h1: fsl_lim_ma = 12'h14a;
      4'h2: fsl_lim_ma = 12'h190;
      4'h3: fsl_lim_ma = 12'h1e0;
      4'h4: fsl_lim_ma = 12'h230;
      4'h5: fsl_lim_ma = 12'h29e;
      4'h6: fsl_lim_ma = 12'h2d0;
      4'h7: fsl_lim_ma = 12'h352;
      4'h8: fsl_lim_ma = 12'h3e8;
      4'h9: fsl_lim_ma = 12'h44c;
      4'ha: fsl_lim_ma = 12'h4e2;
      4'hb: fsl_lim_ma = 12'h5dc;
      4'hc: fsl_lim_ma = 12'h640;
      4'hd: fsl_lim_ma = 12'h6d6;
      4'he: fsl_lim_ma = 12'h76c;
      default: fsl_lim_ma = 12'h898;
    endcase
  endfunction
endpackage

//--- verif/fsl_host_model.sv
// host controller model: register accesses as one-cycle strobes
// assumes strobes are sampled on the rising core_clk edge
`timescale 1ns/100ps
module fsl_host_model (
  input wire logic core_clk,
  input wire logic [7:0] reg_rdata_q,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // every access also restarts the watchdog
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    // released lines show no stale value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge core_clk);
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    d = reg_rdata_q;
  endtask
endmodule // fsl_host_model

//--- verif/testbench.sv
// self-checking bench for the fail-safe and current-limit registers
// assumes the host model drives the register strobes
`timescale 1ns/100ps
module testbench;
  import fsl_pkg::*;
  logic core_clk, sys_rst, spi_error, split_limit_select, limit_duration_mode, watchdog_enable_bit;
  logic reg_wr_en, reg_rd_en, duration_mode_q, watchdog_error_q, failsafe_active_q;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, d, v;
  logic [3:0] sw_state, chan_on_q;
  logic [1:0] watchdog_timeout_sel;
  fsl_limit_t limit_ch12_q, limit_ch34_q;
  int failures = 0;
  int checked = 0;
  int k;
  int ms_t[16] = '{0, 2, 4, 6, 8, 10, 12, 16, 20, 24, 28, 32, 40, 48, 56, 64};
  int ma_t[16] = '{250, 330, 400, 480, 560, 670, 720, 850, 1000, 1100, 1250, 1500, 1600, 1750, 1900, 2200};
  logic [7:0] rst_v[4] = '{8'h00, 8'h0a, 8'h0a, 8'h00};
  fsl_failsafe_regs #(.WD_CYC_0(20), .WD_CYC_1(40), .WD_CYC_2(60), .WD_CYC_3(80)) u_fsl_failsafe_regs (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .sw_state(sw_state),
    .spi_error(spi_error), .split_limit_select(split_limit_select), .limit_duration_mode(limit_duration_mode),
    .watchdog_enable_bit(watchdog_enable_bit), .watchdog_timeout_sel(watchdog_timeout_sel),
    .chan_on_q(chan_on_q), .limit_ch12_q(limit_ch12_q), .limit_ch34_q(limit_ch34_q),
    .duration_mode_q(duration_mode_q), .watchdog_error_q(watchdog_error_q), .failsafe_active_q(failsafe_active_q));
  fsl_host_model u_host (.core_clk(core_clk), .reg_rdata_q(reg_rdata_q), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  function automatic logic [18:0] lim(input logic [7:0] c);
    return {7'(ms_t[c[7:4]]), 12'(ma_t[c[3:0]])};
  endfunction
  task automatic chk(input string n, input logic [18:0] e, input logic [18:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    {sys_rst, spi_error, split_limit_select, limit_duration_mode, watchdog_enable_bit} = 5'h10;
    sw_state = 4'h0;
    watchdog_timeout_sel = 2'h0;
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    chk("lim12", lim(8'h0a), limit_ch12_q);
    for (int i = 0; i < 4; i++) begin
      u_host.rd(8'h20 + 8'(i), d);
      chk("reset", 19'(rst_v[i]), 19'(d));
    end
    u_host.wr(FSL_ADDR_FAILSAFE, 8'hff);
    u_host.rd(FSL_ADDR_FAILSAFE, d);
    chk("fs", 19'h0f, 19'(d));
    for (int i = 0; i < 16; i++) begin
      v = {4'(i), 4'(15 - i)};
      u_host.wr(FSL_ADDR_CFG_A, v);
      @(negedge core_clk);
      chk("lim12", lim(v), limit_ch12_q);
      chk("lim34", lim(v), limit_ch34_q);
    end
    split_limit_select = 1'b1;
    for (int i = 0; i < 16; i++) begin
      v = {4'(15 - i), 4'(i)};
      u_host.wr(FSL_ADDR_CFG_B, v);
      @(negedge core_clk);
      chk("lim34", lim(v), limit_ch34_q);
      chk("lim12", lim(8'hf0), limit_ch12_q);
    end
    for (int m = 0; m < 2; m++) begin
      limit_duration_mode = m[0];
      @(negedge core_clk);
      chk("mode", 19'(m), 19'(duration_mode_q));
    end
    u_host.wr(FSL_ADDR_FAILSAFE, 8'h05);
    sw_state = 4'ha;
    spi_error = 1'b1;
    @(negedge core_clk);
    chk("chan", 19'h15, 19'({failsafe_active_q, chan_on_q}));
    spi_error = 1'b0;
    @(negedge core_clk);
    chk("chan", 19'h0a, 19'({failsafe_active_q, chan_on_q}));
    watchdog_enable_bit = 1'b1;
    for (int s = 0; s < 4; s++) begin
      watchdog_timeout_sel = 2'(s);
      u_host.rd(FSL_ADDR_CFG_A, d);
      repeat (20 * (s + 1) - 5) @(negedge core_clk);
      chk("wd", 19'h0, 19'(watchdog_error_q));
      for (k = 0; k < 10 && watchdog_error_q !== 1'b1; k++) @(negedge core_clk);
      chk("wd", 19'h1, 19'(watchdog_error_q));
      if (watchdog_error_q !== 1'b1) end_sim;
      @(negedge core_clk);
      chk("chan", 19'h15, 19'({failsafe_active_q, chan_on_q}));
    end
    u_host.rd(FSL_ADDR_FAILSAFE, d);
    chk("wd", 19'h0, 19'(watchdog_error_q));
    sys_rst = 1'b1;
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 3; i++) begin
      u_host.rd(8'h20 + 8'(i), d);
      chk("rerst", 19'(rst_v[i]), 19'(d));
    end
    chk("lim34", lim(8'h0a), limit_ch34_q);
    end_sim;
  end
endmodule // testbench
